// file: core/slls_pkg.sv
// ==========================================================
// lane link status: shared constants and carriers
// ==========================================================
package slls_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;

  // ==========================================================
  // register indices; byte address is four times the index
  // ==========================================================
  localparam logic [ADDR_W-1:0] IDX_LANE6_FLAGS = 16'h04B6;
  localparam logic [ADDR_W-1:0] IDX_LANE7_FLAGS = 16'h04B7;
  localparam logic [ADDR_W-1:0] IDX_LINK_CTRL = 16'h04C0;
  localparam logic [ADDR_W-1:0] ADDR_LANE6_FLAGS = IDX_LANE6_FLAGS << 2;
  localparam logic [ADDR_W-1:0] ADDR_LANE7_FLAGS = IDX_LANE7_FLAGS << 2;
  localparam logic [ADDR_W-1:0] ADDR_LINK_CTRL = IDX_LINK_CTRL << 2;

  // ==========================================================
  // status byte fields
  // ==========================================================
  localparam int BIT_DISPARITY = 7;
  localparam int BIT_INVALID_SYM = 6;
  localparam int BIT_UNEXP_CHAR = 5;
  localparam int BIT_DESKEW = 4;
  localparam int BIT_ALIGN_SYNC = 3;
  localparam int BIT_CHECKSUM = 2;
  localparam int BIT_FRAME_SYNC = 1;
  localparam int BIT_GROUP_SYNC = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ==========================================================
  // control word fields
  // ==========================================================
  localparam int CTRL_THR_LSB = 0;
  localparam int CTRL_SKIP_BIT = 8;
  localparam logic [CNT_W-1:0] THRESHOLD_RESET = 8'hFF;
  localparam logic SKIP_RESET = 1'b0;

  typedef struct packed {
    logic [CNT_W-1:0] disp_err_cnt;
    logic [CNT_W-1:0] invalid_sym_cnt;
    logic [CNT_W-1:0] unexp_char_cnt;
    logic [7:0] calc_cksum;
    logic [7:0] rx_cksum;
    logic deskew_ok;
    logic lane_align_sync_ok;
    logic frame_sync_ok;
    logic symbol_group_sync_ok;
  } slls_lane_in_t;

endpackage : slls_pkg

// file: core/slls_lane_flags.sv
`timescale 1ns/1ps
// ==========================================================
// one lane's live status byte
// ==========================================================
module slls_lane_flags #(
  parameter int CNT_W = slls_pkg::CNT_W
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input slls_pkg::slls_lane_in_t lane_in,
  input wire logic [CNT_W-1:0] error_threshold,
  output logic [7:0] flags_q
);

  logic [7:0] flags_d;

  always_comb begin
    flags_d = slls_pkg::FLAGS_RESET;
    // counts compared live, so with a nonzero threshold a flag drops again once the counter is cleared
    flags_d[slls_pkg::BIT_DISPARITY] = lane_in.disp_err_cnt >= error_threshold;
    flags_d[slls_pkg::BIT_INVALID_SYM] = lane_in.invalid_sym_cnt >= error_threshold;
    flags_d[slls_pkg::BIT_UNEXP_CHAR] = lane_in.unexp_char_cnt >= error_threshold;
    flags_d[slls_pkg::BIT_DESKEW] = lane_in.deskew_ok;
    flags_d[slls_pkg::BIT_ALIGN_SYNC] = lane_in.lane_align_sync_ok;
    flags_d[slls_pkg::BIT_CHECKSUM] = lane_in.calc_cksum == lane_in.rx_cksum;
    flags_d[slls_pkg::BIT_FRAME_SYNC] = lane_in.frame_sync_ok;
    flags_d[slls_pkg::BIT_GROUP_SYNC] = lane_in.symbol_group_sync_ok;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flags_q <= slls_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : slls_lane_flags

// file: core/slls_top.sv
// Summary of operation
// - each lane's bit 7 is 1 while its disparity error count is at or above the threshold.
// - each lane's bit 6 is 1 while its invalid-symbol count is at or above the threshold.
// - each lane's bit 5 is 1 while its unexpected-character count is at or above the threshold.
// - bit 4 shows 1 when interlane deskew succeeded and 0 when it failed.
// - bit 3 shows 1 while initial lane alignment sync is held and 0 once lost.
// - bit 2 shows 1 when the computed and received config checksums match.
// - bit 1 shows 1 while frame sync is achieved and 0 when lost.
// - bit 0 shows 1 while code group sync is achieved and 0 when lost.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module slls_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [slls_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slls_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [slls_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input slls_pkg::slls_lane_in_t lane6_in,
  input slls_pkg::slls_lane_in_t lane7_in,
  output logic [7:0] lane6_flags,
  output logic [7:0] lane7_flags,
  output logic skip_lane_alignment_seq
);

  // ==========================================================
  // control state
  // ==========================================================
  logic [slls_pkg::CNT_W-1:0] thr_q;
  logic [slls_pkg::CNT_W-1:0] thr_d;
  logic skip_q;
  logic skip_d;

  // ==========================================================
  // bus answer state
  // ==========================================================
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic [slls_pkg::DATA_W-1:0] prdata_q;
  logic [slls_pkg::DATA_W-1:0] prdata_d;
  logic access;
  logic commit;
  logic hit_l6;
  logic hit_l7;
  logic hit_ctrl;

  assign access = psel && penable;
  // a write lands only on the edge where pready is seen high
  assign commit = access && pready_q;
  assign hit_l6 = paddr == slls_pkg::ADDR_LANE6_FLAGS;
  assign hit_l7 = paddr == slls_pkg::ADDR_LANE7_FLAGS;
  assign hit_ctrl = paddr == slls_pkg::ADDR_LINK_CTRL;

  // ==========================================================
  // per-lane status bytes
  // ==========================================================
  slls_lane_flags #(
    .CNT_W(slls_pkg::CNT_W)
  ) u_lane6 (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lane_in(lane6_in),
    .error_threshold(thr_q),
    .flags_q(lane6_flags)
  );

  slls_lane_flags #(
    .CNT_W(slls_pkg::CNT_W)
  ) u_lane7 (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .lane_in(lane7_in),
    .error_threshold(thr_q),
    .flags_q(lane7_flags)
  );

  // ==========================================================
  // apb slave: one wait state, answer registered
  // ==========================================================
  always_comb begin
    pready_d = access && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (access && !pready_q) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = !(hit_l6 || hit_l7 || hit_ctrl);
      if (!pwrite && hit_l6) begin
        prdata_d[7:0] = lane6_flags;
      end else if (!pwrite && hit_l7) begin
        prdata_d[7:0] = lane7_flags;
      end else if (!pwrite && hit_ctrl) begin
        prdata_d[slls_pkg::CTRL_THR_LSB +: slls_pkg::CNT_W] = thr_q;
        prdata_d[slls_pkg::CTRL_SKIP_BIT] = skip_q;
      end
    end else if (access) begin
      pslverr_d = pslverr_q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pready_d ? pslverr_d : 1'b0;
      prdata_q <= prdata_d;
    end
  end

  // ==========================================================
  // control register; status bytes have no write path
  // ==========================================================
  always_comb begin
    thr_d = thr_q;
    skip_d = skip_q;
    if (commit && pwrite && hit_ctrl) begin
      if (pstrb[0]) begin
        thr_d = pwdata[slls_pkg::CTRL_THR_LSB +: slls_pkg::CNT_W];
      end
      if (pstrb[1]) begin
        skip_d = pwdata[slls_pkg::CTRL_SKIP_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      thr_q <= slls_pkg::THRESHOLD_RESET;
      skip_q <= slls_pkg::SKIP_RESET;
    end else begin
      thr_q <= thr_d;
      skip_q <= skip_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // exported so firmware knows when bits 4..1 carry no meaning
  assign skip_lane_alignment_seq = skip_q;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_disp_flag_l6: assert property (
    !$past(sys_rst) |-> lane6_flags[slls_pkg::BIT_DISPARITY] ==
      ($past(lane6_in.disp_err_cnt) >= $past(thr_q)))
    else $error("lane6 disparity flag wrong");

  chk_invalid_sym_l7: assert property (
    !$past(sys_rst) |-> lane7_flags[slls_pkg::BIT_INVALID_SYM] ==
      ($past(lane7_in.invalid_sym_cnt) >= $past(thr_q)))
    else $error("lane7 invalid symbol flag wrong");

  chk_unexp_char_flag: assert property (
    (lane6_in.unexp_char_cnt < thr_q) ##1 !$past(sys_rst, 2) |->
      !lane6_flags[slls_pkg::BIT_UNEXP_CHAR])
    else $error("unexpected char flag set below threshold");

  chk_deskew_follow: assert property (
    $rose(lane7_in.deskew_ok) |=> lane7_flags[slls_pkg::BIT_DESKEW])
    else $error("deskew bit did not follow");

  // the byte lags its input by one edge, so the loss shows as a fall one cycle on
  chk_align_loss: assert property (
    $fell(lane6_in.lane_align_sync_ok) && !$past(sys_rst) |=>
      $fell(lane6_flags[slls_pkg::BIT_ALIGN_SYNC]))
    else $error("alignment loss not shown");

  chk_cksum_match: assert property (
    !$past(sys_rst) |-> lane7_flags[slls_pkg::BIT_CHECKSUM] ==
      ($past(lane7_in.calc_cksum) == $past(lane7_in.rx_cksum)))
    else $error("checksum bit wrong");

  chk_frame_sync: assert property (
    lane6_in.frame_sync_ok [*2] ##0 !$past(sys_rst) |-> lane6_flags[slls_pkg::BIT_FRAME_SYNC])
    else $error("frame sync bit low while synced");

  chk_group_sync: assert property (
    !lane7_in.symbol_group_sync_ok ##1 1'b1 |-> !lane7_flags[slls_pkg::BIT_GROUP_SYNC])
    else $error("group sync bit high while lost");

  chk_flags_reset: assert property (@(posedge ref_clk)
    $past(sys_rst) |-> lane6_flags == slls_pkg::FLAGS_RESET &&
      lane7_flags == slls_pkg::FLAGS_RESET)
    else $error("status not cleared by reset");

  chk_read_status: assert property (
    access && !pready_q && !pwrite && hit_l6 |=>
      pready && prdata == {24'h00_0000, $past(lane6_flags)} && !pslverr)
    else $error("lane6 status read wrong");

  chk_read_lane7: assert property (
    access && !pready_q && !pwrite && hit_l7 |=>
      pready && prdata == {24'h00_0000, $past(lane7_flags)} && !pslverr)
    else $error("lane7 status read wrong");

  chk_read_ctrl: assert property (
    access && !pready_q && !pwrite && hit_ctrl |=>
      pready && prdata == {23'h00_0000, $past(skip_q), $past(thr_q)} && !pslverr)
    else $error("control read wrong");

  chk_unmapped_err: assert property (
    access && !pready_q && !(hit_l6 || hit_l7 || hit_ctrl) |=>
      pready && pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_ready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  cov_read_l6: cover property (access && pready_q && !pwrite && hit_l6);
  cov_read_l7: cover property (access && pready_q && !pwrite && hit_l7);
  cov_write_ctrl: cover property (commit && pwrite && hit_ctrl);
  cov_unmapped: cover property (pready && pslverr);
  cov_align_loss: cover property ($fell(lane6_flags[slls_pkg::BIT_ALIGN_SYNC]));

endmodule : slls_top

// file: test/slls_lane_src.sv
`timescale 1ns/1ps
// ==========================================================
// far side: transmitter-driven receive state of one lane
// ==========================================================
module slls_lane_src (
  input wire logic ref_clk,
  input wire logic stall,
  input slls_pkg::slls_lane_in_t next_st,
  output slls_pkg::slls_lane_in_t lane_q
);
  // a stalled link keeps its old state, so late updates are seen too
  always_ff @(posedge ref_clk) begin
    if (!stall) begin
      lane_q <= next_st;
    end
  end
endmodule : slls_lane_src

// file: test/serial_lane_link_status_6_7_tb.sv
`timescale 1ns/1ps
module serial_lane_link_status_6_7_tb;
  logic ref_clk, sys_rst, psel, penable, pwrite, stall, pready, pslverr, skip;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] f6, f7, thr;
  logic [33:0] cur;
  logic [33:0] expq[$];
  int failures, cmp_count;
  slls_pkg::slls_lane_in_t n6, n7, l6, l7;
  localparam logic [15:0] A6 = slls_pkg::ADDR_LANE6_FLAGS;
  localparam logic [15:0] A7 = slls_pkg::ADDR_LANE7_FLAGS;
  localparam logic [15:0] AC = slls_pkg::ADDR_LINK_CTRL;
  localparam logic [7:0] THR0 = slls_pkg::THRESHOLD_RESET;

  slls_top dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane6_in(l6), .lane7_in(l7), .lane6_flags(f6),
    .lane7_flags(f7), .skip_lane_alignment_seq(skip));
  slls_lane_src src6_u (.ref_clk(ref_clk), .stall(stall), .next_st(n6), .lane_q(l6));
  slls_lane_src src7_u (.ref_clk(ref_clk), .stall(stall), .next_st(n7), .lane_q(l7));

  // ==========================================================
  // checking
  // ==========================================================
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [7:0] flags_of(slls_pkg::slls_lane_in_t l, logic [7:0] t);
    flags_of = {l.disp_err_cnt >= t, l.invalid_sym_cnt >= t, l.unexp_char_cnt >= t,
      l.deskew_ok, l.lane_align_sync_ok, l.calc_cksum == l.rx_cksum, l.frame_sync_ok,
      l.symbol_group_sync_ok};
  endfunction : flags_of

  // counts land at threshold-1, threshold or threshold+1: the edges of the compare
  function automatic slls_pkg::slls_lane_in_t rnd_lane(logic [7:0] t);
    slls_pkg::slls_lane_in_t l;
    l = slls_pkg::slls_lane_in_t'(44'({$urandom, $urandom}));
    l.disp_err_cnt = t + 8'($urandom_range(2)) - 8'h01;
    l.invalid_sym_cnt = t + 8'($urandom_range(2)) - 8'h01;
    l.unexp_char_cnt = t + 8'($urandom_range(2)) - 8'h01;
    if ($urandom_range(1) == 1) begin
      l.rx_cksum = l.calc_cksum;
    end
    rnd_lane = l;
  endfunction : rnd_lane

  // exp: {compare data, expected error, expected data}
  task automatic apb(logic [15:0] a, logic w, logic [31:0] d, logic [3:0] s, logic [33:0] exp);
    int n;
    @(posedge ref_clk);
    expq.push_back(exp);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge ref_clk);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  always @(posedge ref_clk) begin
    if (pready === 1'b1) begin
      cur = expq.pop_front();
      check({31'h0, pslverr}, {31'h0, cur[32]});
      if (cur[33]) check(prdata, cur[31:0]);
    end
  end

  // ==========================================================
  // stimulus
  // ==========================================================
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, stall} = 4'h0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    n6 = '0;
    n6.rx_cksum = 8'h01;
    n7 = n6;
    void'($urandom(79334));
    repeat (10) @(posedge ref_clk);
    check({16'h0, f6, f7}, 32'h0000_0000);
    sys_rst <= 1'b0;
    apb(A6, 1'b0, 32'h0, 4'hF, {2'b10, 32'h0});
    apb(A7, 1'b1, 32'hFFFF_FFFF, 4'hF, {2'b00, 32'h0});
    apb(A7, 1'b0, 32'h0, 4'hF, {2'b10, 32'h0});
    apb(AC, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, THR0});
    apb(16'h0000, 1'b0, 32'h0, 4'hF, {2'b11, 32'h0});
    apb(A6 + 16'h0001, 1'b1, 32'h0, 4'hF, {2'b01, 32'h0});
    for (int i = 0; i < 24; i++) begin
      thr = 8'($urandom_range(254, 1));
      apb(AC, 1'b1, {24'h0, thr}, 4'hF, 34'h0);
      n6 <= rnd_lane(thr);
      n7 <= rnd_lane(thr);
      stall <= 1'b1;
      repeat (2) @(posedge ref_clk);
      stall <= 1'b0;
      repeat (3) @(posedge ref_clk);
      // the pins themselves, not only the bus copy
      check({24'h0, f6}, {24'h0, flags_of(n6, thr)});
      check({24'h0, f7}, {24'h0, flags_of(n7, thr)});
      apb(A6, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, flags_of(n6, thr)});
      apb(A7, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, flags_of(n7, thr)});
    end
    apb(AC, 1'b1, 32'h0000_0155, 4'hF, 34'h0);
    apb(AC, 1'b0, 32'h0, 4'hF, {2'b10, 32'h0000_0155});
    check({31'h0, skip}, 32'h0000_0001);
    apb(A7, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, flags_of(n7, 8'h55)});
    // low byte strobe only: threshold drops to zero, skip bit stays
    apb(AC, 1'b1, 32'h0000_0000, 4'h1, 34'h0);
    apb(AC, 1'b0, 32'h0, 4'hF, {2'b10, 32'h0000_0100});
    repeat (2) @(posedge ref_clk);
    apb(A6, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, flags_of(n6, 8'h00)});
    // mid-run reset: flags must clear although counts sit above the threshold
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({16'h0, f6, f7}, 32'h0000_0000);
    sys_rst <= 1'b0;
    apb(AC, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, THR0});
    apb(A6, 1'b0, 32'h0, 4'hF, {2'b10, 24'h0, flags_of(n6, THR0)});
    check({31'h0, skip}, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    report_and_stop();
  end
endmodule : serial_lane_link_status_6_7_tb
